// ===== verilog/gsb_pkg.sv
// Summary of operation
// RULE_01 - bits 4-6 of select ctrl choose status b
// RULE_02 - codes 0-3 map to T1/E1 alarm sources, 4-5 to signaling change and slip
// RULE_03 - codes 6 and 7 drive zero
// RULE_04 - host writes zero to bits 3 and 7
// RULE_05 - first view read drives interrupt status
// RULE_06 - second view read drives sync loss
// RULE_07 - third view read drives status a
// RULE_08 - fourth view read drives status b
// RULE_09 - views decode at B2h through B5h
// RULE_10 - disabled member never drives shared lines; the code still drives all eight on B0h/B1h reads
// RULE_11 - bit 0 of line ctrl enables participation
// RULE_12 - bits 1-3 choose driven data line
// RULE_13 - host gives each member a unique line
// RULE_14 - bits 0-2 of select ctrl choose status a
package gsb_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] GSB_ADDR_LINE_CTRL   = 8'hB0;
	localparam logic [7:0] GSB_ADDR_SELECT_CTRL = 8'hB1;
	localparam logic [7:0] GSB_ADDR_IRQ_VIEW    = 8'hB2;
	localparam logic [7:0] GSB_ADDR_SYNC_VIEW   = 8'hB3;
	localparam logic [7:0] GSB_ADDR_STAT_A_VIEW = 8'hB4;
	localparam logic [7:0] GSB_ADDR_STAT_B_VIEW = 8'hB5;

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int         GSB_ENABLE_BIT     = 0;
	localparam int         GSB_LINE_SEL_LSB   = 1;
	localparam int         GSB_STAT_A_SEL_LSB = 0;
	localparam int         GSB_STAT_B_SEL_LSB = 4;
	localparam logic [7:0] GSB_LINE_CTRL_MASK = 8'h0F;
	localparam logic [7:0] GSB_SEL_CTRL_MASK  = 8'h77;
	localparam logic [7:0] GSB_CTRL_RESET     = 8'h00;

	// ----------------------------------------
	// status select codes
	// ----------------------------------------
	localparam logic [2:0] GSB_SEL_ALARM_A  = 3'h0;
	localparam logic [2:0] GSB_SEL_ALARM_B  = 3'h1;
	localparam logic [2:0] GSB_SEL_ALARM_C  = 3'h2;
	localparam logic [2:0] GSB_SEL_ALARM_D  = 3'h3;
	localparam logic [2:0] GSB_SEL_SIG_CHG  = 3'h4;
	localparam logic [2:0] GSB_SEL_ES_SLIP  = 3'h5;

endpackage

// ===== verilog/gsb_status_mux.sv
module gsb_status_mux
	import gsb_pkg::*;
(
	// selection
	input  wire logic [2:0] sel_i,
	input  wire logic       e1_mode_i,
	// sources
	input  wire logic       blue_alarm_receive_i,
	input  wire logic       yellow_alarm_receive_i,
	input  wire logic       loop_up_detect_i,
	input  wire logic       loop_down_detect_i,
	input  wire logic       unframed_all_ones_receive_i,
	input  wire logic       remote_alarm_receive_i,
	input  wire logic       distant_multiframe_alarm_i,
	input  wire logic       v5_link_detect_i,
	input  wire logic       signaling_change_i,
	input  wire logic       elastic_store_slip_i,
	// result
	output logic            status_o
);

	always_comb begin
		case (sel_i) // RULE_02
			GSB_SEL_ALARM_A: status_o = e1_mode_i ? unframed_all_ones_receive_i
			                                      : blue_alarm_receive_i;
			GSB_SEL_ALARM_B: status_o = e1_mode_i ? remote_alarm_receive_i
			                                      : yellow_alarm_receive_i;
			GSB_SEL_ALARM_C: status_o = e1_mode_i ? distant_multiframe_alarm_i
			                                      : loop_up_detect_i;
			GSB_SEL_ALARM_D: status_o = e1_mode_i ? v5_link_detect_i : loop_down_detect_i;
			GSB_SEL_SIG_CHG: status_o = signaling_change_i;
			GSB_SEL_ES_SLIP: status_o = elastic_store_slip_i;
			default:         status_o = 1'b0; // RULE_03
		endcase
	end

endmodule

// ===== verilog/gsb_group_status.sv
module gsb_group_status
	import gsb_pkg::*;
(
	// clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       nrst_i,
	// host register port, same clock
	input  wire logic [7:0] addr_i,
	input  wire logic       rd_i,
	input  wire logic       wr_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] rdata_o,
	output logic      [7:0] rdata_oe_n_o,
	// device mode and status from pins
	input  wire logic       e1_mode_i,
	input  wire logic       irq_pending_i,
	input  wire logic       sync_loss_i,
	input  wire logic       blue_alarm_receive_i,
	input  wire logic       yellow_alarm_receive_i,
	input  wire logic       loop_up_detect_i,
	input  wire logic       loop_down_detect_i,
	input  wire logic       unframed_all_ones_receive_i,
	input  wire logic       remote_alarm_receive_i,
	input  wire logic       distant_multiframe_alarm_i,
	input  wire logic       v5_link_detect_i,
	input  wire logic       signaling_change_i,
	input  wire logic       elastic_store_slip_i
);

	// ----------------------------------------
	// status synchronisers
	// ----------------------------------------
	// status comes from other clock domains, so two stages before use
	localparam int NSTAT = 13;
	logic [NSTAT-1:0] stat_raw;
	logic [NSTAT-1:0] stat_meta;
	logic [NSTAT-1:0] stat_s;
	assign stat_raw = {e1_mode_i, irq_pending_i, sync_loss_i, blue_alarm_receive_i,
	                   yellow_alarm_receive_i, loop_up_detect_i, loop_down_detect_i,
	                   unframed_all_ones_receive_i, remote_alarm_receive_i,
	                   distant_multiframe_alarm_i, v5_link_detect_i,
	                   signaling_change_i, elastic_store_slip_i};

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			stat_meta <= '0;
			stat_s    <= '0;
		end else begin
			stat_meta <= stat_raw;
			stat_s    <= stat_meta;
		end
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	logic [7:0] line_ctrl;
	logic [7:0] select_ctrl;
	logic [7:0] next_line_ctrl;
	logic [7:0] next_select_ctrl;

	always_comb begin
		next_line_ctrl   = line_ctrl;
		next_select_ctrl = select_ctrl;
		if (wr_i && addr_i == GSB_ADDR_LINE_CTRL)
			next_line_ctrl = wdata_i & GSB_LINE_CTRL_MASK;
		// unused bits held at zero whatever the host writes
		if (wr_i && addr_i == GSB_ADDR_SELECT_CTRL)
			next_select_ctrl = wdata_i & GSB_SEL_CTRL_MASK; // RULE_04
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			line_ctrl   <= GSB_CTRL_RESET;
			select_ctrl <= GSB_CTRL_RESET;
		end else begin
			line_ctrl   <= next_line_ctrl;
			select_ctrl <= next_select_ctrl;
		end
	end

	logic       group_bus_enable;
	logic [2:0] bus_line_select;
	logic [2:0] status_a_select;
	logic [2:0] status_b_select;
	assign group_bus_enable = line_ctrl[GSB_ENABLE_BIT]; // RULE_11
	assign bus_line_select  = line_ctrl[GSB_LINE_SEL_LSB +: 3]; // RULE_12
	assign status_a_select  = select_ctrl[GSB_STAT_A_SEL_LSB +: 3]; // RULE_14
	assign status_b_select  = select_ctrl[GSB_STAT_B_SEL_LSB +: 3]; // RULE_01

	// ----------------------------------------
	// user status selection
	// ----------------------------------------
	logic status_a;
	logic status_b;

	gsb_status_mux u_mux_a (
		.sel_i                       (status_a_select),
		.e1_mode_i                   (stat_s[12]),
		.blue_alarm_receive_i        (stat_s[9]),
		.yellow_alarm_receive_i      (stat_s[8]),
		.loop_up_detect_i            (stat_s[7]),
		.loop_down_detect_i          (stat_s[6]),
		.unframed_all_ones_receive_i (stat_s[5]),
		.remote_alarm_receive_i      (stat_s[4]),
		.distant_multiframe_alarm_i  (stat_s[3]),
		.v5_link_detect_i            (stat_s[2]),
		.signaling_change_i          (stat_s[1]),
		.elastic_store_slip_i        (stat_s[0]),
		.status_o                    (status_a)
	);

	gsb_status_mux u_mux_b (
		.sel_i                       (status_b_select),
		.e1_mode_i                   (stat_s[12]),
		.blue_alarm_receive_i        (stat_s[9]),
		.yellow_alarm_receive_i      (stat_s[8]),
		.loop_up_detect_i            (stat_s[7]),
		.loop_down_detect_i          (stat_s[6]),
		.unframed_all_ones_receive_i (stat_s[5]),
		.remote_alarm_receive_i      (stat_s[4]),
		.distant_multiframe_alarm_i  (stat_s[3]),
		.v5_link_detect_i            (stat_s[2]),
		.signaling_change_i          (stat_s[1]),
		.elastic_store_slip_i        (stat_s[0]),
		.status_o                    (status_b)
	);

	// ----------------------------------------
	// read answer
	// ----------------------------------------
	// a view read is answered on one line only; the other seven belong to peers
	logic [7:0] next_rdata;
	logic [7:0] next_oe_n;
	logic       view_bit;
	logic       is_view;

	always_comb begin
		view_bit = 1'b0;
		is_view  = 1'b1;
		case (addr_i) // RULE_09
			GSB_ADDR_IRQ_VIEW:    view_bit = stat_s[11]; // RULE_05
			GSB_ADDR_SYNC_VIEW:   view_bit = stat_s[10]; // RULE_06
			GSB_ADDR_STAT_A_VIEW: view_bit = status_a; // RULE_07
			GSB_ADDR_STAT_B_VIEW: view_bit = status_b; // RULE_08
			default:              is_view  = 1'b0;
		endcase
		next_rdata = 8'h00;
		next_oe_n  = 8'hFF;
		if (rd_i) begin
			if (is_view) begin
				if (group_bus_enable) begin // RULE_10
					next_rdata[bus_line_select] = view_bit;
					next_oe_n[bus_line_select]  = 1'b0;
				end
			end else if (addr_i == GSB_ADDR_LINE_CTRL) begin
				next_rdata = line_ctrl;
				next_oe_n  = 8'h00;
			end else if (addr_i == GSB_ADDR_SELECT_CTRL) begin
				next_rdata = select_ctrl;
				next_oe_n  = 8'h00;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			rdata_o      <= 8'h00;
			rdata_oe_n_o <= 8'hFF;
		end else begin
			rdata_o      <= next_rdata;
			rdata_oe_n_o <= next_oe_n;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_DISABLED_SILENT: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE_10
		rd_i && !group_bus_enable && addr_i >= GSB_ADDR_IRQ_VIEW
		&& addr_i <= GSB_ADDR_STAT_B_VIEW |=> rdata_oe_n_o == 8'hFF)
		else $error("disabled member drove the shared bus");

	AST_ONE_LINE: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE_12
		rd_i && group_bus_enable && addr_i >= GSB_ADDR_IRQ_VIEW
		&& addr_i <= GSB_ADDR_STAT_B_VIEW
		|=> rdata_oe_n_o == ~(8'h01 << $past(bus_line_select)))
		else $error("view read drove wrong line set");

	AST_IRQ_VIEW: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE_05
		rd_i && group_bus_enable && addr_i == GSB_ADDR_IRQ_VIEW
		|=> rdata_o[$past(bus_line_select)] == $past(stat_s[11]))
		else $error("interrupt view bit wrong");

	AST_SYNC_VIEW: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE_06
		rd_i && group_bus_enable && addr_i == GSB_ADDR_SYNC_VIEW
		|=> rdata_o[$past(bus_line_select)] == $past(stat_s[10]))
		else $error("sync loss view bit wrong");

	AST_STAT_A_VIEW: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE_07
		rd_i && group_bus_enable && addr_i == GSB_ADDR_STAT_A_VIEW
		|=> rdata_o[$past(bus_line_select)] == $past(status_a))
		else $error("status a view bit wrong");

	AST_STAT_B_SLIP: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE_08
		rd_i && group_bus_enable && addr_i == GSB_ADDR_STAT_B_VIEW
		&& status_b_select == GSB_SEL_ES_SLIP
		|=> rdata_o[$past(bus_line_select)] == $past(stat_s[0]))
		else $error("status b slip bit wrong");

	AST_UNDEF_ZERO: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE_03
		status_a_select > GSB_SEL_ES_SLIP |-> !status_a)
		else $error("undefined select code gave nonzero status");

	AST_SEL_MASK: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE_01
		wr_i && addr_i == GSB_ADDR_SELECT_CTRL
		|=> status_b_select == $past(wdata_i[6:4]) && select_ctrl[3] == 1'b0
		&& select_ctrl[7] == 1'b0)
		else $error("select ctrl write not taken");

	AST_E1_MAP: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // RULE_02
		status_a_select == GSB_SEL_ALARM_A && stat_s[12] |-> status_a == stat_s[5])
		else $error("E1 code 0 did not select all-ones");

endmodule

// ===== bench/gsb_peer_model.sv
module gsb_peer_model (
	// host bus
	input  wire logic       core_clk_i,
	input  wire logic       rd_i,
	input  wire logic [7:0] addr_i,
	// own setup and status
	input  wire logic [2:0] line_i,
	input  wire logic       status_i,
	// shared data lines
	output logic      [7:0] bus_o,
	output logic      [7:0] bus_oe_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial bus_o = 8'h5A;
	// released lines toggle so a stale value can never pass for a driven one
	always @(posedge core_clk_i) begin
		bus_oe_n_o <= 8'hFF;
		bus_o      <= ~bus_o;
		if (rd_i && addr_i >= 8'hB2 && addr_i <= 8'hB5) begin
			bus_oe_n_o[line_i] <= 1'b0;
			bus_o[line_i]      <= status_i;
		end
	end
endmodule

// ===== bench/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import gsb_pkg::*;
	logic       core_clk_i, nrst_i, rd_i, wr_i, e1_mode_i, irq_i, sync_i;
	logic [7:0] addr_i, wdata_i, rdata_o, rdata_oe_n_o, p_bus, p_oe_n, bus, got, got_oe;
	logic [9:0] src;
	logic [2:0] line;
	int         mismatches, tests_run;
	int         cycles = 0;

	// ----------------------------------------
	// device, peer and shared bus
	// ----------------------------------------
	gsb_group_status DUT (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
		.rd_i(rd_i), .wr_i(wr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
		.rdata_oe_n_o(rdata_oe_n_o), .e1_mode_i(e1_mode_i), .irq_pending_i(irq_i),
		.sync_loss_i(sync_i), .blue_alarm_receive_i(src[0]), .yellow_alarm_receive_i(src[1]),
		.loop_up_detect_i(src[2]), .loop_down_detect_i(src[3]),
		.unframed_all_ones_receive_i(src[4]), .remote_alarm_receive_i(src[5]),
		.distant_multiframe_alarm_i(src[6]), .v5_link_detect_i(src[7]),
		.signaling_change_i(src[8]), .elastic_store_slip_i(src[9]));
	gsb_peer_model peer (.core_clk_i(core_clk_i), .rd_i(rd_i), .addr_i(addr_i),
		.line_i(~line), .status_i(1'b1), .bus_o(p_bus), .bus_oe_n_o(p_oe_n));
	assign bus = (rdata_o & ~rdata_oe_n_o) | (p_bus & ~p_oe_n);

	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			results();
		end
	end

	// ----------------------------------------
	// bus cycles and comparison
	// ----------------------------------------
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		wr_i    <= 1'b1;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk_i);
		rd_i   <= 1'b1;
		addr_i <= a;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1;
		got    = bus;
		got_oe = rdata_oe_n_o;
	endtask
	// our line carries e, the peer on the inverted line carries 1
	task automatic view(input logic [7:0] a, input logic [2:0] ln, input logic e);
		logic [7:0] m;
		m = (8'h01 << ln) | (8'h01 << (~ln));
		rd(a);
		chk(got_oe, ~(8'h01 << ln));
		chk(got & m, ({7'h00, e} << ln) | (8'h01 << (~ln)));
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd(GSB_ADDR_LINE_CTRL);
		chk(got, 8'h00);
		rd(GSB_ADDR_SELECT_CTRL);
		chk(got, 8'h00);
		rd(GSB_ADDR_IRQ_VIEW);
		chk(got_oe, 8'hFF);
	endtask
	task automatic t_mask();
		wr(GSB_ADDR_SELECT_CTRL, 8'h77);
		rd(GSB_ADDR_SELECT_CTRL);
		chk(got, 8'h77);
		wr(GSB_ADDR_LINE_CTRL, 8'hFF);
		rd(GSB_ADDR_LINE_CTRL);
		chk(got, 8'h0F);
		chk(got_oe, 8'h00);
		rd(8'hB6);
		chk(got_oe, 8'hFF);
	endtask
	// both polarities, so a stuck or swapped line cannot pass
	task automatic t_fixed();
		for (int v = 0; v < 2; v++) begin
			@(posedge core_clk_i);
			irq_i  <= v[0];
			sync_i <= !v[0];
			line   <= 3'h3;
			wr(GSB_ADDR_LINE_CTRL, 8'h07);
			view(GSB_ADDR_IRQ_VIEW, 3'h3, v[0]);
			view(GSB_ADDR_SYNC_VIEW, 3'h3, !v[0]);
		end
		// the answer stands one cycle, then the line is released again
		@(posedge core_clk_i);
		#1;
		chk(rdata_oe_n_o, 8'hFF);
		wr(GSB_ADDR_LINE_CTRL, 8'h06);
		rd(GSB_ADDR_STAT_B_VIEW);
		chk(got_oe, 8'hFF);
	endtask
	// every code in both modes; codes 0-5 once with only the chosen source high and
	// once with all others high, codes 6 and 7 with all high and all low; the line follows the code
	task automatic t_select();
		logic [9:0] s;
		for (int e = 0; e < 2; e++) begin
			for (int c = 0; c < 8; c++) begin
				for (int h = 0; h < 2; h++) begin
					s = (c < 4) ? 10'h001 << (c + 4 * e) : (c < 6 ? 10'h001 << (c + 4) : 10'h3FF);
					if (h == 1) begin
						s = ~s;
					end
					@(posedge core_clk_i);
					e1_mode_i <= e[0];
					src       <= s;
					line      <= c[2:0];
					wr(GSB_ADDR_LINE_CTRL, {4'h0, c[2:0], 1'b1});
					wr(GSB_ADDR_SELECT_CTRL, {1'b0, c[2:0], 1'b0, c[2:0]});
					view(GSB_ADDR_STAT_A_VIEW, c[2:0], c < 6 && h == 0);
					view(GSB_ADDR_STAT_B_VIEW, c[2:0], c < 6 && h == 0);
				end
			end
		end
	endtask

	task automatic results();
		if (mismatches == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		nrst_i = 1'b0;
		{rd_i, wr_i, e1_mode_i, irq_i, sync_i} = 5'h00;
		addr_i = 8'h00;
		wdata_i = 8'h00;
		src = 10'h000;
		line = 3'h0;
		mismatches = 0;
		tests_run = 0;
		repeat (8) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		t_reset();
		t_mask();
		t_fixed();
		t_select();
		results();
	end
endmodule
